// ==== logic/safe_cam_position_monitor.sv ====
// Two-channel safe cam monitor with APB registers
`default_nettype none
// How it works
// - Up to thirty cams, each individually enabled
// - Each cam bounded by plus/minus edges
// - Too short cam raises parameter fault
// - Channels may differ inside edge band
// - Function enable bit 28 gates all but motion status bit 23
// - Enable bit x gates cam x
// - Outputs live at once, safe after referencing
// - Control word two bit 23 selects
// - Channel disagreement raises fault value 1014
// - Position crosscheck uses actual tolerance
// - Results reported when configured, selected and telegram 903 is active
// - Function needs an encoder present
// - Motion status bit 23 shows referenced
module safe_cam_position_monitor
  import cam_monitor_pkg::*;
#(
  parameter int N = NUM_CAMS
) (
  input  wire logic         clk_sys_i,       // System clock, 100 MHz
  input  wire logic         nrst_i,          // Sync reset, active low
  input  wire apb_req_t     apb_i,           // APB request
  output var apb_rsp_t      apb_o,           // APB response
  input  wire pos_pair_t    pos_i,           // Both channel positions
  input  wire logic         monitor_tick_i,  // Monitoring cycle strobe
  input  wire logic         encoder_ok_i,    // Position encoder present
  input  wire logic         referenced_i,    // Axis safely referenced
  input  wire logic [31:0]  ctrl_word_two_i, // Safety control word two
  input  wire logic [15:0]  telegram_id_i,   // Active telegram number
  output logic [N-1:0]      cam_status_o,    // Cam status word
  output logic              cam_safe_o,      // Cam outputs are safe
  output logic [31:0]       motion_status_o, // Motion status signals
  output logic              param_fault_o,   // Cam parameter fault
  output logic [15:0]       fault_value_o,   // Crosscheck fault value
  output logic              irq_o            // Interrupt level
);
  typedef struct packed {
    bus_st_t                 bus;
    apb_rsp_t                rsp;
    logic [31:0]             func_en;
    logic [N-1:0]            cam_en;
    logic [31:0]             cam_tol;
    logic [31:0]             xtol;
    logic [N-1:0][31:0]      plus;
    logic [N-1:0][31:0]      minus;
    logic [N-1:0]            cam_status;
    logic                    cam_safe;
    logic [31:0]             motion;
    logic                    param_fault;
    logic                    param_pulse;
    logic                    xchk_pulse;
    logic [15:0]             fault_val;
  } state_t;

  state_t          q;
  state_t          s;
  logic [N-1:0]    in_a;
  logic [N-1:0]    in_b;
  logic [N-1:0]    param_bad;
  logic [N-1:0]    mismatch;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic            done_c;
  logic            rd_clr_c;
  logic            mask_wr_c;
  logic            configured_c;
  logic            active_c;
  logic            pos_gap_c;
  logic signed [POS_W:0] gap;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cam
      cam_slice #(.W(POS_W)) u_cam (
        .pos_a_i     (pos_i.pos_a),
        .pos_b_i     (pos_i.pos_b),
        .plus_i      ($signed(q.plus[g])),
        .minus_i     ($signed(q.minus[g])),
        .cam_tol_i   (q.cam_tol),
        .xtol_i      (q.xtol),
        .enable_i    (q.cam_en[g]),
        .in_a_o      (in_a[g]),
        .in_b_o      (in_b[g]),
        .param_bad_o (param_bad[g]),
        .mismatch_o  (mismatch[g])
      );
    end
  endgenerate

  event_flags #(.W(EVT_W)) u_evt (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .set_i       ({q.xchk_pulse, q.param_pulse}),
    .rd_clr_i    (rd_clr_c),
    .mask_wr_i   (mask_wr_c),
    .mask_data_i (apb_i.pwdata[EVT_W-1:0]),
    .status_o    (evt_status),
    .mask_o      (evt_mask),
    .irq_o       (irq_o)
  );

  assign configured_c = q.func_en[FUNC_EN_CAM_BIT] && encoder_ok_i;
  assign active_c = configured_c && ctrl_word_two_i[SCW2_CAM_BIT] &&
                    (telegram_id_i == TELEGRAM_CAM);

  assign gap = {pos_i.pos_a[POS_W-1], pos_i.pos_a} -
               {pos_i.pos_b[POS_W-1], pos_i.pos_b};
  assign pos_gap_c = ((gap < 0) ? $unsigned(-gap) : $unsigned(gap)) >
                     {1'b0, q.xtol};

  assign done_c    = (q.bus == BUS_DONE) && apb_i.psel && apb_i.penable;
  assign rd_clr_c  = done_c && !apb_i.pwrite &&
                     (apb_i.paddr == OFS_EVT_STATUS);
  assign mask_wr_c = done_c && apb_i.pwrite &&
                     (apb_i.paddr == OFS_EVT_MASK);

  always_comb begin
    logic [5:0]  idx;
    logic [31:0] rdata;
    logic        hit;
    s = q;
    idx = apb_i.paddr[7:2];
    rdata = WORD_ZERO;
    hit = 1'b1;
    case (apb_i.paddr[ADDR_W-1:8])
      PAGE_REGS: begin
        case (apb_i.paddr)
          OFS_FUNC_EN:    rdata = q.func_en;
          OFS_CAM_EN:     rdata = 32'(q.cam_en);
          OFS_CAM_TOL:    rdata = q.cam_tol;
          OFS_XTOL:       rdata = q.xtol;
          OFS_CAM_STATUS: rdata = 32'(q.cam_status);
          OFS_MOTION:     rdata = q.motion;
          OFS_EVT_STATUS: rdata = 32'(evt_status);
          OFS_EVT_MASK:   rdata = 32'(evt_mask);
          OFS_FAULT_VAL:  rdata = 32'(q.fault_val);
          default:        hit = 1'b0;
        endcase
      end
      PAGE_PLUS: begin
        hit = idx < CAM_IDX_LIMIT;
        rdata = hit ? q.plus[idx] : WORD_ZERO;
      end
      PAGE_MINUS: begin
        hit = idx < CAM_IDX_LIMIT;
        rdata = hit ? q.minus[idx] : WORD_ZERO;
      end
      default: hit = 1'b0;
    endcase
    if (apb_i.paddr[1:0] != 2'h0) begin
      hit = 1'b0;
      rdata = WORD_ZERO;
    end

    // Slave answers with one wait state; write lands on the ready edge
    case (q.bus)
      BUS_IDLE: begin
        if (apb_i.psel && apb_i.penable) begin
          s.bus = BUS_DONE;
          s.rsp.pready = 1'b1;
          s.rsp.pslverr = !hit;
          s.rsp.prdata = apb_i.pwrite ? WORD_ZERO : rdata;
        end
      end
      BUS_DONE: begin
        s.bus = BUS_IDLE;
        s.rsp.pready = 1'b0;
        s.rsp.pslverr = 1'b0;
        if (done_c && apb_i.pwrite && hit) begin
          case (apb_i.paddr[ADDR_W-1:8])
            PAGE_PLUS:  s.plus[idx] = apb_i.pwdata;
            PAGE_MINUS: s.minus[idx] = apb_i.pwdata;
            default: begin
              case (apb_i.paddr)
                OFS_FUNC_EN: s.func_en = apb_i.pwdata;
                OFS_CAM_EN:  s.cam_en = apb_i.pwdata[N-1:0];
                OFS_CAM_TOL: s.cam_tol = apb_i.pwdata;
                OFS_XTOL:    s.xtol = apb_i.pwdata;
                default:     s.cam_en = q.cam_en;
              endcase
            end
          endcase
        end
      end
      default: begin
        s.bus = BUS_IDLE;
        s.rsp.pready = 1'b0;
      end
    endcase

    s.motion[MOTION_REF_BIT] = referenced_i;
    s.cam_safe = referenced_i && active_c;
    s.param_pulse = 1'b0;
    s.xchk_pulse = 1'b0;
    if (monitor_tick_i) begin
      s.cam_status = active_c ? (in_a & in_b) : '0;
      s.param_fault = configured_c && (|param_bad);
      s.param_pulse = s.param_fault;
      s.xchk_pulse = active_c && ((|mismatch) || pos_gap_c);
      if (s.xchk_pulse) begin
        s.fault_val = FAULT_VAL_XCHK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.bus <= BUS_IDLE;
      q.fault_val <= FAULT_VAL_NONE;
    end else begin
      q <= s;
    end
  end

  assign apb_o           = q.rsp;
  assign cam_status_o    = q.cam_status;
  assign cam_safe_o      = q.cam_safe;
  assign motion_status_o = q.motion;
  assign param_fault_o   = q.param_fault;
  assign fault_value_o   = q.fault_val;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  func_gate_a: assert property (
    monitor_tick_i && !q.func_en[FUNC_EN_CAM_BIT] |=> cam_status_o == '0)
    else $error("cam status set with function disabled");
  enable_gate_a: assert property (
    monitor_tick_i |=> (cam_status_o & ~$past(q.cam_en)) == '0)
    else $error("disabled cam reported active");
  select_gate_a: assert property (
    monitor_tick_i && !ctrl_word_two_i[SCW2_CAM_BIT] |=> cam_status_o == '0)
    else $error("cam status without selection");
  encoder_gate_a: assert property (
    monitor_tick_i && !encoder_ok_i |=> cam_status_o == '0 && !param_fault_o)
    else $error("cam function active without encoder");
  param_fault_a: assert property (
    monitor_tick_i && configured_c && (|param_bad)
    |=> param_fault_o ##1 evt_status[EVT_PARAM])
    else $error("short cam did not raise fault");
  xchk_value_a: assert property (
    monitor_tick_i && active_c && (|mismatch)
    |=> fault_value_o == FAULT_VAL_XCHK ##1 evt_status[EVT_XCHK])
    else $error("crosscheck fault value wrong");
  band_ok_a: assert property (
    monitor_tick_i && ~|mismatch && !pos_gap_c |=> !q.xchk_pulse)
    else $error("edge band disagreement flagged");
  ref_bit_a: assert property (
    ##1 motion_status_o[MOTION_REF_BIT] == $past(referenced_i))
    else $error("referenced bit does not follow");
  safe_flag_a: assert property (
    cam_safe_o |-> $past(referenced_i))
    else $error("cams marked safe before referencing");
  inside_cam_a: assert property (
    monitor_tick_i && active_c && in_a[0] && in_b[0] |=> cam_status_o[0])
    else $error("cam inside window not reported");
  param_clear_a: assert property (
    monitor_tick_i && !(|param_bad) |=> !param_fault_o)
    else $error("parameter fault without short cam");
  cam_outside_a: assert property (
    monitor_tick_i && !in_a[0] |=> !cam_status_o[0])
    else $error("cam outside window reported");
  safe_set_a: assert property (
    referenced_i && active_c |=> cam_safe_o)
    else $error("referenced active cams not marked safe");
  fault_hold_a: assert property (
    fault_value_o == FAULT_VAL_XCHK |=> fault_value_o == FAULT_VAL_XCHK)
    else $error("crosscheck fault value lost");
  gap_fault_a: assert property (
    monitor_tick_i && active_c && pos_gap_c |=> q.xchk_pulse)
    else $error("channel gap beyond tolerance not flagged");
  telegram_gate_a: assert property (
    monitor_tick_i && telegram_id_i != TELEGRAM_CAM |=> cam_status_o == '0)
    else $error("cam status with wrong telegram");
  irq_level_a: assert property (
    irq_o == |(evt_status & evt_mask))
    else $error("interrupt level does not match flags");
  bus_wait_a: assert property (
    apb_i.psel && apb_i.penable && q.bus == BUS_IDLE |=> apb_o.pready)
    else $error("no ready after one wait state");

  cam_on_c: cover property (monitor_tick_i && active_c && (|(in_a & in_b)));
  safe_c: cover property (cam_safe_o && (|cam_status_o));
  xchk_c: cover property (q.xchk_pulse);
  param_c: cover property (q.param_pulse);
  rd_clr_c_c: cover property (rd_clr_c && |evt_status);
endmodule // safe_cam_position_monitor
`default_nettype wire

// ==== logic/cam_monitor_pkg.sv ====
// Constants, register map and carrier types of the safe cam monitor
`default_nettype none
package cam_monitor_pkg;
  localparam int NUM_CAMS = 30;
  localparam int POS_W    = 32;
  localparam int ADDR_W   = 12;
  localparam int EVT_W    = 2;

  localparam logic [ADDR_W-1:0] OFS_FUNC_EN    = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CAM_EN     = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CAM_TOL    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_XTOL       = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_CAM_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MOTION     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_FAULT_VAL  = 12'h020;
  localparam logic [3:0]        PAGE_PLUS      = 4'h1;
  localparam logic [3:0]        PAGE_MINUS     = 4'h2;
  localparam logic [3:0]        PAGE_REGS      = 4'h0;
  localparam logic [5:0]        CAM_IDX_LIMIT  = 6'h1e;

  localparam int FUNC_EN_CAM_BIT = 28;
  localparam int SCW2_CAM_BIT    = 23;
  localparam int MOTION_REF_BIT  = 23;
  localparam int EVT_PARAM       = 0;
  localparam int EVT_XCHK        = 1;

  localparam logic [15:0] TELEGRAM_CAM   = 16'h0387;
  localparam logic [15:0] FAULT_VAL_XCHK = 16'h03f6;
  localparam logic [15:0] FAULT_VAL_NONE = 16'h0000;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic signed [POS_W-1:0] pos_a;
    logic signed [POS_W-1:0] pos_b;
  } pos_pair_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_st_t;
endpackage
`default_nettype wire

// ==== logic/cam_slice.sv ====
// Per-cam window, edge band and length check for both channels
`default_nettype none
module cam_slice
  import cam_monitor_pkg::*;
#(
  parameter int W = POS_W
) (
  input  wire logic signed [W-1:0] pos_a_i,     // Channel A position
  input  wire logic signed [W-1:0] pos_b_i,     // Channel B position
  input  wire logic signed [W-1:0] plus_i,      // Upper cam edge
  input  wire logic signed [W-1:0] minus_i,     // Lower cam edge
  input  wire logic        [W-1:0] cam_tol_i,   // Edge band width
  input  wire logic        [W-1:0] xtol_i,      // Channel tolerance
  input  wire logic                enable_i,    // Cam takes part
  output logic                     in_a_o,      // Channel A inside
  output logic                     in_b_o,      // Channel B inside
  output logic                     param_bad_o, // Cam too short
  output logic                     mismatch_o   // Disagree outside band
);
  logic signed [W+1:0] len;
  logic signed [W+1:0] min_len;
  logic                near_a;
  logic                near_b;

  function automatic logic near_edge(input logic signed [W-1:0] p,
                                     input logic signed [W-1:0] e,
                                     input logic        [W-1:0] t);
    logic signed [W:0] d;
    d = W'(1) == 0 ? '0 : ({p[W-1], p} - {e[W-1], e});
    if (d < 0) begin
      d = -d;
    end
    return $unsigned(d) <= {1'b0, t};
  endfunction

  assign in_a_o = enable_i && (pos_a_i >= minus_i) && (pos_a_i <= plus_i);
  assign in_b_o = enable_i && (pos_b_i >= minus_i) && (pos_b_i <= plus_i);

  assign len     = {{2{plus_i[W-1]}}, plus_i} - {{2{minus_i[W-1]}}, minus_i};
  assign min_len = {2'b00, cam_tol_i} + {2'b00, xtol_i};
  assign param_bad_o = enable_i && (len < min_len);

  assign near_a = near_edge(pos_a_i, plus_i, cam_tol_i) ||
                  near_edge(pos_a_i, minus_i, cam_tol_i);
  assign near_b = near_edge(pos_b_i, plus_i, cam_tol_i) ||
                  near_edge(pos_b_i, minus_i, cam_tol_i);
  assign mismatch_o = (in_a_o != in_b_o) && !(near_a || near_b);
endmodule // cam_slice
`default_nettype wire

// ==== logic/event_flags.sv ====
// Sticky event flags with mask and registered interrupt
`default_nettype none
module event_flags #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,   // System clock
  input  wire logic         nrst_i,      // Sync reset, active low
  input  wire logic [W-1:0] set_i,       // Event pulses
  input  wire logic         rd_clr_i,    // Status read completes
  input  wire logic         mask_wr_i,   // Mask write completes
  input  wire logic [W-1:0] mask_data_i, // New mask value
  output logic      [W-1:0] status_o,    // Sticky flags
  output logic      [W-1:0] mask_o,      // Mask register
  output logic              irq_o        // Interrupt level
);
  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic         irq;
  } flags_t;

  flags_t q;
  flags_t s;

  always_comb begin
    s = q;
    // A new event wins over a clearing read in the same cycle
    s.status = (rd_clr_i ? '0 : q.status) | set_i;
    if (mask_wr_i) begin
      s.mask = mask_data_i;
    end
    s.irq = |(s.status & s.mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign status_o = q.status;
  assign mask_o   = q.mask;
  assign irq_o    = q.irq;
endmodule // event_flags
`default_nettype wire

// ==== sim/host_ctrl_model.sv ====
// Host controller model: selects the cam function, reads back cam status
`default_nettype none
module host_ctrl_model
  import cam_monitor_pkg::*;
(
  input  wire logic        clk_sys_i,    // System clock
  input  wire logic        nrst_i,       // Sync reset, active low
  input  wire logic        select_i,     // Bench asks for the cam function
  input  wire logic        slow_i,       // Apply selection after a delay
  input  wire logic        bad_tgm_i,    // Bench commands a wrong telegram
  input  wire logic [29:0] cam_status_i, // Reported cam status word
  output var  logic [31:0] ctrl_word_o,  // Safety control word two
  output var  logic [15:0] telegram_o,   // Telegram in use
  output var  logic [29:0] cam_seen_o    // Last cam status received
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lag_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      lag_r       <= 3'h0;
      ctrl_word_o <= 32'h0;
      telegram_o  <= 16'h0;
      cam_seen_o  <= 30'h0;
    end else begin
      if (!select_i) begin
        lag_r <= 3'h0;
      end else if (slow_i && lag_r != 3'h4) begin
        lag_r <= lag_r + 3'h1;
      end
      // select via bit 23, telegram 903
      ctrl_word_o[23] <= select_i && (!slow_i || lag_r == 3'h4);
      telegram_o      <= bad_tgm_i ? 16'h0386 : 16'h0387;
      cam_seen_o      <= cam_status_i;
    end
  end
endmodule // host_ctrl_model
`default_nettype wire

// ==== sim/safe_cam_position_monitor_tb_top.sv ====
// Self-checking bench for the safe cam monitor
`default_nettype none
module safe_cam_position_monitor_tb_top
  import cam_monitor_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  apb_req_t    apb_i     = '0;
  apb_rsp_t    apb_o;
  pos_pair_t   pos_i     = '0;
  logic        tick_r    = 1'b0;
  logic        enc_r     = 1'b0;
  logic        ref_r     = 1'b0;
  logic        sel_r     = 1'b0;
  logic        slow_r    = 1'b0;
  logic        badt_r    = 1'b0;
  logic [31:0] cw2;
  logic [15:0] tgm;
  logic [29:0] cam_st;
  logic [29:0] seen;
  logic        cam_safe;
  logic        pfault;
  logic        irq;
  logic [31:0] motion;
  logic [15:0] fval;
  logic [31:0] rd;
  logic        err;
  int          fails      = 0;
  int          n_compared = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  safe_cam_position_monitor dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
    .pos_i(pos_i), .monitor_tick_i(tick_r), .encoder_ok_i(enc_r),
    .referenced_i(ref_r), .ctrl_word_two_i(cw2), .telegram_id_i(tgm),
    .cam_status_o(cam_st), .cam_safe_o(cam_safe), .motion_status_o(motion),
    .param_fault_o(pfault), .fault_value_o(fval), .irq_o(irq));

  host_ctrl_model host (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .select_i(sel_r),
    .slow_i(slow_r), .bad_tgm_i(badt_r), .cam_status_i(cam_st),
    .ctrl_word_o(cw2), .telegram_o(tgm), .cam_seen_o(seen));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    apb_i.psel    <= 1'b1;
    apb_i.pwrite  <= wr;
    apb_i.paddr   <= a;
    apb_i.pwdata  <= d;
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    // Sample ready at the rising edge and release at that same edge
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (apb_o.pready === 1'b1) begin
        break;
      end
    end
    if (i == 20) begin
      fails++;
      complete_run();
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic cam(input int x, input logic [31:0] lo,
                     input logic [31:0] hi);
    bus(1'b1, {PAGE_MINUS, 8'(4 * x)}, lo);
    bus(1'b1, {PAGE_PLUS, 8'(4 * x)}, hi);
  endtask

  task automatic tick(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk_sys_i);
    pos_i.pos_a <= a;
    pos_i.pos_b <= b;
    tick_r <= 1'b1;
    @(posedge clk_sys_i);
    tick_r <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic t_regs();
    bus(1'b0, OFS_CAM_EN, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h3fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, 12'h002, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, {PAGE_PLUS, 8'h78}, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b1, OFS_CAM_STATUS, 32'hffff_ffff);
    bus(1'b0, OFS_CAM_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_window();
    bus(1'b1, OFS_FUNC_EN, 32'h1000_0000);
    bus(1'b1, OFS_CAM_EN, 32'h2000_0001);
    bus(1'b1, OFS_CAM_TOL, 32'h5);
    bus(1'b1, OFS_XTOL, 32'h3);
    cam(0, 32'd100, 32'd200);
    cam(1, 32'd0, 32'd1);
    cam(29, -32'sd50, 32'sd50);
    bus(1'b0, {PAGE_PLUS, 8'h00}, 32'h0);
    chk(rd, 32'd200);
    @(posedge clk_sys_i);
    sel_r <= 1'b1;
    enc_r <= 1'b1;
    tick(32'd150, 32'd150);
    chk({2'h0, cam_st}, 32'h1);
    chk({31'h0, cam_safe}, 32'h0);
    chk({31'h0, pfault}, 32'h0);
    tick(32'd200, 32'd200);
    chk({2'h0, cam_st}, 32'h1);
    chk({2'h0, seen}, 32'h1);
    tick(32'd201, 32'd201);
    chk({2'h0, cam_st}, 32'h0);
    tick(-32'sd50, -32'sd50);
    chk({2'h0, cam_st}, 32'h2000_0000);
    bus(1'b0, OFS_CAM_STATUS, 32'h0);
    chk(rd, 32'h2000_0000);
    @(posedge clk_sys_i);
    ref_r <= 1'b1;
    tick(32'd150, 32'd150);
    chk(motion, 32'h0080_0000);
    chk({31'h0, cam_safe}, 32'h1);
    $display("test window done");
  endtask

  task automatic t_gate();
    for (int k = 0; k < 5; k++) begin
      if (k == 0) begin
        bus(1'b1, OFS_FUNC_EN, 32'h0);
      end
      @(posedge clk_sys_i);
      sel_r <= (k != 1);
      badt_r <= (k == 2);
      enc_r <= (k != 3);
      slow_r <= (k == 4);
      repeat (8) @(posedge clk_sys_i);
      tick(32'd150, 32'd150);
      chk({2'h0, cam_st}, {31'h0, k == 4});
      bus(1'b1, OFS_FUNC_EN, 32'h1000_0000);
    end
    $display("test gate done");
  endtask

  task automatic t_param();
    bus(1'b1, OFS_CAM_EN, 32'h2000_0005);
    bus(1'b1, OFS_EVT_MASK, 32'h3);
    cam(2, 32'd300, 32'd307);
    tick(32'd150, 32'd150);
    chk({31'h0, pfault}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h1);
    cam(2, 32'd300, 32'd308);
    tick(32'd150, 32'd150);
    chk({31'h0, pfault}, 32'h0);
    bus(1'b0, OFS_EVT_STATUS, 32'h0);
    bus(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h0);
    @(negedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    $display("test param done");
  endtask

  task automatic t_xchk();
    tick(32'd198, 32'd201);
    chk({16'h0, fval}, 32'h0);
    chk({2'h0, cam_st}, 32'h0);
    tick(32'd150, 32'd154);
    chk({16'h0, fval}, 32'h03f6);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h2);
    // Channels disagree well away from any cam edge
    tick(32'd90, 32'd110);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h2);
    $display("test crosscheck done");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_regs();
    t_window();
    t_gate();
    t_param();
    t_xchk();
    complete_run();
  end
endmodule // safe_cam_position_monitor_tb_top
`default_nettype wire
